// ---- src/dual_data_pointer_control.sv ----
`timescale 1ns/1ps
module dual_data_pointer_control (
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire pointer_pkg::sfr_req_s   sfr_i,
	input  wire pointer_pkg::ptr_load_s  load_i,
	input  wire pointer_pkg::move_kind_e move_i,
	output logic [7:0]                   rdata_o,
	output logic                         rvalid_o,
	output logic [15:0]                  active_pointer_o,
	output logic                         pointer_select_o,
	output logic [7:0]                   pointer_control_o
);
	import pointer_pkg::*;

	// stored state
	logic [7:0]  pointer_control;   // control register, writable bits only
	logic [15:0] main_ptr;          // main pointer
	logic [15:0] shadow_ptr;        // shadow pointer
	// next values and combinational helpers
	logic [15:0] next_main;         // main pointer after this cycle
	logic [15:0] next_shadow;       // shadow pointer after this cycle
	logic [7:0]  next_control;      // control after this cycle
	logic        sel;               // current selection
	logic        ptr_move;          // a move through the pointer
	logic [15:0] active;            // selected pointer value
	ptr_mode_e   active_mode;       // mode of the selected pointer
	logic [15:0] modified;          // selected pointer after post-modify

	// the select bit decides which pointer every pointer instruction sees
	assign sel = pointer_control[SEL_BIT];
	// only the at-pointer forms qualify; pc and indirect-byte forms do not
	assign ptr_move = (move_i == MOVE_CODE_PTR) || (move_i == MOVE_XDATA_PTR);
	// the selected pointer, used for reads, post-modification and byte views
	assign active = sel ? shadow_ptr : main_ptr;
	assign active_mode = sel ? ptr_mode_e'(pointer_control[SHADOW_MODE_LO +: 2])
	                         : ptr_mode_e'(pointer_control[MAIN_MODE_LO +: 2]);

	// post-modification of whichever pointer is active
	// both ends wrap: an increment of ffff gives 0000, a decrement of 0000 gives ffff
	always_comb begin
		// the mode comes from the field of the pointer in use, not always the main one
		case (active_mode)
			MODE_KEEP:   modified = active;
			MODE_INC:    modified = 16'(active + 16'h0001);
			MODE_DEC:    modified = 16'(active - 16'h0001);
			MODE_TOGGLE: modified = active ^ 16'h0001;
			default:     modified = active;
		endcase
	end

	// next pointer values: byte writes and loads hit the selected pointer only
	always_comb begin
		// by default both pointers hold their value
		next_main   = main_ptr;
		next_shadow = shadow_ptr;
		if (load_i.load) begin
			// a full load wins over a move in the same cycle
			if (sel) next_shadow = load_i.value;
			else     next_main   = load_i.value;
		end else if (sfr_i.wr && sfr_i.addr == ADDR_POINTER_LOW) begin
			// low byte only; the high byte of that pointer is kept
			if (sel) next_shadow[7:0] = sfr_i.wdata;
			else     next_main[7:0]   = sfr_i.wdata;
		end else if (sfr_i.wr && sfr_i.addr == ADDR_POINTER_HIGH) begin
			// high byte only; the low byte of that pointer is kept
			if (sel) next_shadow[15:8] = sfr_i.wdata;
			else     next_main[15:8]   = sfr_i.wdata;
		end else if (ptr_move) begin
			// a pointer write in the same cycle wins and this step is lost;
			// software must not rely on both landing together
			// the pointer that addressed the move is the pre-swap active one
			if (sel) next_shadow = modified;
			else     next_main   = modified;
		end
	end

	// next control value: software write, else automatic swap
	always_comb begin
		next_control = pointer_control;
		// a software write beats an automatic swap in the same cycle
		if (sfr_i.wr && sfr_i.addr == ADDR_POINTER_CONTROL) begin
			// software write; unimplemented bits 7 and 1 are forced to zero
			next_control = sfr_i.wdata & CTRL_WMASK;
		end else if (move_i == MOVE_XDATA_PTR && pointer_control[SWAP_BIT]) begin
			// code reads never swap, whatever the enable holds
			// swap applies after the modify above, since both use the old select
			next_control[SEL_BIT] = ~sel;
		end
	end

	// control register
	// reset clears the select, both mode fields and the swap enable together
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) pointer_control <= CTRL_RESET;
		else          pointer_control <= next_control;
	end

	// pointer storage
	// both pointers clear on reset so that a first move starts from zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			main_ptr   <= PTR_RESET;
			shadow_ptr <= PTR_RESET;
		end else begin
			main_ptr   <= next_main;
			shadow_ptr <= next_shadow;
		end
	end

	// read port: one-cycle latency, unmapped addresses read zero
	// data follows the address every cycle; rvalid_o alone marks a real read
	// a read sees the values from before the writes of the same edge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= sfr_i.rd;
			case (sfr_i.addr)
				ADDR_POINTER_CONTROL: rdata_o <= pointer_control;
				ADDR_POINTER_LOW:     rdata_o <= active[7:0];
				ADDR_POINTER_HIGH:    rdata_o <= active[15:8];
				default:              rdata_o <= 8'h00;
			endcase
		end
	end

	// a high byte read answers with the selected pointer one cycle later
	property p_rdhigh;
		@(posedge clk_i) disable iff (!rst_n_i)
		sfr_i.rd && sfr_i.addr == ADDR_POINTER_HIGH |=> rdata_o == $past(active[15:8]);
	endproperty
	a_rdhigh: assert property (p_rdhigh) else $error("high byte read wrong");

	// control reads back what is stored, unimplemented bits as zero
	property p_rdctrl;
		@(posedge clk_i) disable iff (!rst_n_i)
		sfr_i.rd && sfr_i.addr == ADDR_POINTER_CONTROL
		|=> rdata_o == $past(pointer_control);
	endproperty
	a_rdctrl: assert property (p_rdctrl) else $error("control read wrong");

	// addresses outside this block read as zero
	property p_rdnone;
		@(posedge clk_i) disable iff (!rst_n_i)
		sfr_i.rd && sfr_i.addr != ADDR_POINTER_CONTROL && sfr_i.addr != ADDR_POINTER_LOW
		&& sfr_i.addr != ADDR_POINTER_HIGH |=> rdata_o == 8'h00;
	endproperty
	a_rdnone: assert property (p_rdnone) else $error("unmapped read not zero");

	// registered views for the core's address path
	// built from next values so that each view matches the state after the edge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_pointer_o  <= PTR_RESET;
			pointer_select_o  <= 1'b0;
			pointer_control_o <= CTRL_RESET;
		end else begin
			active_pointer_o  <= next_control[SEL_BIT] ? next_shadow : next_main;
			pointer_select_o  <= next_control[SEL_BIT];
			pointer_control_o <= next_control;
		end
	end

	// the views never lag the state that they stand for
	property p_view;
		@(posedge clk_i) disable iff (!rst_n_i)
		active_pointer_o == active && pointer_select_o == sel;
	endproperty
	a_view: assert property (p_view) else $error("pointer view wrong");

	// the control view shows the stored control register
	property p_ctrlview;
		@(posedge clk_i) disable iff (!rst_n_i)
		pointer_control_o == pointer_control;
	endproperty
	a_ctrlview: assert property (p_ctrlview) else $error("control view wrong");

	// the modify and swap checks look only at quiet cycles, where nothing overrides the step
	// quiet cycle: no load, no write
	logic quiet;
	assign quiet = !load_i.load && !sfr_i.wr;

	property p_inc;
		@(posedge clk_i) disable iff (!rst_n_i)
		quiet && ptr_move && active_mode == MODE_INC
		|=> (($past(sel) ? shadow_ptr : main_ptr) == 16'($past(active) + 16'h0001));
	endproperty
	a_inc: assert property (p_inc) else $error("increment missing");

	property p_dec;
		@(posedge clk_i) disable iff (!rst_n_i)
		quiet && ptr_move && active_mode == MODE_DEC
		|=> (($past(sel) ? shadow_ptr : main_ptr) == 16'($past(active) - 16'h0001));
	endproperty
	a_dec: assert property (p_dec) else $error("decrement missing");

	property p_tog;
		@(posedge clk_i) disable iff (!rst_n_i)
		quiet && ptr_move && active_mode == MODE_TOGGLE
		|=> (($past(sel) ? shadow_ptr : main_ptr) == ($past(active) ^ 16'h0001));
	endproperty
	a_tog: assert property (p_tog) else $error("bit toggle missing");

	property p_keep;
		@(posedge clk_i) disable iff (!rst_n_i)
		quiet && (!ptr_move || active_mode == MODE_KEEP)
		|=> $stable(main_ptr) && $stable(shadow_ptr);
	endproperty
	a_keep: assert property (p_keep) else $error("pointer changed without cause");

	property p_other;
		@(posedge clk_i) disable iff (!rst_n_i)
		quiet && ptr_move |=> (($past(sel) ? main_ptr : shadow_ptr)
		                      == $past(sel ? main_ptr : shadow_ptr));
	endproperty
	a_other: assert property (p_other) else $error("inactive pointer modified");

	property p_swap;
		@(posedge clk_i) disable iff (!rst_n_i)
		quiet && move_i == MOVE_XDATA_PTR
		|=> (sel == ($past(sel) ^ $past(pointer_control[SWAP_BIT])));
	endproperty
	a_swap: assert property (p_swap) else $error("auto swap wrong");

	property p_noswap;
		@(posedge clk_i) disable iff (!rst_n_i)
		quiet && move_i != MOVE_XDATA_PTR |=> $stable(sel);
	endproperty
	a_noswap: assert property (p_noswap) else $error("select changed");

	property p_rdmap;
		@(posedge clk_i) disable iff (!rst_n_i)
		sfr_i.rd && sfr_i.addr == ADDR_POINTER_LOW |=> rdata_o == $past(active[7:0]);
	endproperty
	a_rdmap: assert property (p_rdmap) else $error("low byte read wrong");

	property p_reset;
		@(posedge clk_i) !rst_n_i |=> pointer_control == CTRL_RESET;
	endproperty
	a_reset: assert property (p_reset) else $error("control not cleared");

	// a control write stores the writable bits and beats a swap in that cycle
	property p_ctrlwr;
		@(posedge clk_i) disable iff (!rst_n_i)
		sfr_i.wr && sfr_i.addr == ADDR_POINTER_CONTROL
		|=> pointer_control == ($past(sfr_i.wdata) & CTRL_WMASK);
	endproperty
	a_ctrlwr: assert property (p_ctrlwr) else $error("control write lost");

	// without a control write or an external-data move the control holds
	property p_ctrlhold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!(sfr_i.wr && sfr_i.addr == ADDR_POINTER_CONTROL) && move_i != MOVE_XDATA_PTR
		|=> $stable(pointer_control);
	endproperty
	a_ctrlhold: assert property (p_ctrlhold) else $error("control changed");

	// a low byte write reaches the selected pointer and keeps its high byte
	property p_lowwr;
		@(posedge clk_i) disable iff (!rst_n_i)
		!load_i.load && sfr_i.wr && sfr_i.addr == ADDR_POINTER_LOW
		|=> ($past(sel) ? shadow_ptr : main_ptr)
		    == {$past(active[15:8]), $past(sfr_i.wdata)};
	endproperty
	a_lowwr: assert property (p_lowwr) else $error("low byte write wrong");

	// a high byte write reaches the selected pointer and keeps its low byte
	property p_highwr;
		@(posedge clk_i) disable iff (!rst_n_i)
		!load_i.load && sfr_i.wr && sfr_i.addr == ADDR_POINTER_HIGH
		|=> ($past(sel) ? shadow_ptr : main_ptr)
		    == {$past(sfr_i.wdata), $past(active[7:0])};
	endproperty
	a_highwr: assert property (p_highwr) else $error("high byte write wrong");

	// a byte write never touches the pointer that is not selected
	property p_wrother;
		@(posedge clk_i) disable iff (!rst_n_i)
		!load_i.load && sfr_i.wr
		&& (sfr_i.addr == ADDR_POINTER_LOW || sfr_i.addr == ADDR_POINTER_HIGH)
		|=> ($past(sel) ? main_ptr : shadow_ptr) == $past(sel ? main_ptr : shadow_ptr);
	endproperty
	a_wrother: assert property (p_wrother) else $error("unselected pointer written");

	// a full load replaces the selected pointer, whatever else comes with it
	property p_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		load_i.load |=> ($past(sel) ? shadow_ptr : main_ptr) == $past(load_i.value);
	endproperty
	a_load: assert property (p_load) else $error("pointer load lost");
endmodule : dual_data_pointer_control

// ---- shared/active_pointer_pkg.sv ----
package pointer_pkg;
	// special-function address map of this block
	localparam logic [7:0] ADDR_POINTER_CONTROL = 8'hA7;
	localparam logic [7:0] ADDR_POINTER_LOW     = 8'h82;
	localparam logic [7:0] ADDR_POINTER_HIGH    = 8'h83;
	// pointer_control field positions
	localparam int SEL_BIT        = 0;
	localparam int MAIN_MODE_LO   = 2;
	localparam int SHADOW_MODE_LO = 4;
	localparam int SWAP_BIT       = 6;
	// writable bits; bits 7 and 1 are not implemented and read zero
	localparam logic [7:0] CTRL_WMASK = 8'h7D;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] PTR_RESET = 16'h0000;

	// post-modification mode of one pointer
	typedef enum logic [1:0] {
		MODE_KEEP   = 2'b00,
		MODE_INC    = 2'b01,
		MODE_DEC    = 2'b10,
		MODE_TOGGLE = 2'b11
	} ptr_mode_e;

	// kind of memory move reported by the core
	typedef enum logic [1:0] {
		MOVE_NONE      = 2'b00,
		MOVE_CODE_PTR  = 2'b01,
		MOVE_XDATA_PTR = 2'b11,
		MOVE_OTHER     = 2'b10
	} move_kind_e;

	// special-function register bus access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	// direct pointer load from the core, such as a 16-bit immediate load
	typedef struct packed {
		logic        load;
		logic [15:0] value;
	} ptr_load_s;
endpackage : pointer_pkg

// ---- dv/core_model.sv ----
`timescale 1ns/1ps
// behavioural core: one request per call, launched off the falling edge
module core_model (
	input  wire logic               clk_i,
	output pointer_pkg::sfr_req_s   sfr_o,
	output pointer_pkg::ptr_load_s  load_o,
	output pointer_pkg::move_kind_e move_o
);
	import pointer_pkg::*;
	// idle lines scrambled so that a stale value can never pass for a match
	initial begin
		sfr_o = '{1'b0, 1'b0, 8'hA5, 8'h5A};
		load_o = '{1'b0, 16'hC3C3};
		move_o = MOVE_NONE;
	end
	// one-cycle access; released strobes drop to zero, address and data show the inverse of what was sent
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		sfr_o = '{w, ~w, a, d};
		@(negedge clk_i);
		sfr_o = '{1'b0, 1'b0, ~a, ~d};
	endtask : sfr
	// direct 16-bit load of the selected pointer
	task automatic ld(input logic [15:0] v);
		@(negedge clk_i);
		load_o = '{1'b1, v};
		@(negedge clk_i);
		load_o = '{1'b0, ~v};
	endtask : ld
	// one memory move of the given kind
	task automatic mv(input move_kind_e k);
		@(negedge clk_i);
		move_o = k;
		@(negedge clk_i);
		move_o = MOVE_NONE;
	endtask : mv
endmodule : core_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
	import pointer_pkg::*;
	logic        clk_i = 1'b0;   // core clock, 4 ns
	logic        rst_n_i = 1'b0; // synchronous, active low
	sfr_req_s    sfr;            // bus request from the core model
	ptr_load_s   ld_req;         // pointer load from the core model
	move_kind_e  mv;             // move kind from the core model
	logic [7:0]  rdata;
	logic        rvalid;
	logic [15:0] ptr;
	logic        sel;
	logic [7:0]  ctrl;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cycles = 0;
	// free-running clock
	always #2 clk_i = ~clk_i;
	core_model i_core (.clk_i(clk_i), .sfr_o(sfr), .load_o(ld_req), .move_o(mv));
	dual_data_pointer_control i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_i(sfr),
		.load_i(ld_req), .move_i(mv), .rdata_o(rdata), .rvalid_o(rvalid),
		.active_pointer_o(ptr), .pointer_select_o(sel), .pointer_control_o(ctrl));
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	// read answer is looked at in the one cycle that it stands
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		i_core.sfr(1'b0, a, 8'h00);
		chk("rvalid", {15'h0, rvalid}, 16'h0001);
		chk("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask : rd_chk
	// set control, load the selected pointer, move once, check the result
	task automatic mod_run(input logic [7:0] c, input logic [15:0] v, input move_kind_e k,
		input logic [15:0] exp);
		i_core.sfr(1'b1, ADDR_POINTER_CONTROL, c);
		i_core.ld(v);
		i_core.mv(k);
		chk("pointer", ptr, exp);
	endtask : mod_run
	// reset values, masked bits, unmapped read
	task automatic t_control();
		rd_chk(ADDR_POINTER_CONTROL, CTRL_RESET);
		chk("select", {15'h0, sel}, 16'h0000);
		i_core.sfr(1'b1, ADDR_POINTER_CONTROL, 8'hFF);
		chk("control", {8'h00, ctrl}, 16'h007D);
		rd_chk(ADDR_POINTER_CONTROL, 8'h7D);
		rd_chk(8'hA6, 8'h00);
	endtask : t_control
	// every mode on both pointers; the other field set to catch a mix-up
	task automatic t_modes();
		logic [15:0] m_exp [4] = '{16'h12FE, 16'h12FF, 16'h12FD, 16'h12FF};
		logic [15:0] s_exp [4] = '{16'hFFFF, 16'h0000, 16'hFFFE, 16'hFFFE};
		for (int m = 0; m < 4; m++) begin
			mod_run({2'b00, 2'b01, m[1:0], 2'b00}, 16'h12FE, MOVE_XDATA_PTR, m_exp[m]);
			mod_run({2'b00, m[1:0], 2'b10, 2'b01}, 16'hFFFF, MOVE_CODE_PTR, s_exp[m]);
		end
		mod_run(8'h04, 16'h12FE, MOVE_OTHER, 16'h12FE);
		mod_run(8'h04, 16'h12FE, MOVE_CODE_PTR, 16'h12FF);
	endtask : t_modes
	// byte views follow the select bit
	task automatic t_bytes();
		i_core.sfr(1'b1, ADDR_POINTER_CONTROL, 8'h01);
		i_core.sfr(1'b1, ADDR_POINTER_LOW, 8'h34);
		i_core.sfr(1'b1, ADDR_POINTER_HIGH, 8'h12);
		chk("shadow", ptr, 16'h1234);
		rd_chk(ADDR_POINTER_HIGH, 8'h12);
		i_core.sfr(1'b1, ADDR_POINTER_CONTROL, 8'h00);
		chk("main", ptr, 16'h12FF);
		rd_chk(ADDR_POINTER_LOW, 8'hFF);
	endtask : t_bytes
	// copy loop: modify the active pointer, then swap on external moves only
	task automatic t_swap();
		mod_run(8'h54, 16'h0000, MOVE_NONE, 16'h0000);
		mod_run(8'h55, 16'hD000, MOVE_CODE_PTR, 16'hD001);
		chk("select", {15'h0, sel}, 16'h0001);
		i_core.mv(MOVE_XDATA_PTR);
		chk("select", {15'h0, sel}, 16'h0000);
		chk("pointer", ptr, 16'h0000);
		i_core.mv(MOVE_XDATA_PTR);
		chk("pointer", ptr, 16'hD002);
		mod_run(8'h14, 16'h0007, MOVE_XDATA_PTR, 16'h0008);
		chk("select", {15'h0, sel}, 16'h0000);
	endtask : t_swap
	// reset in mid-run clears the control and the selection again
	task automatic t_reset();
		i_core.sfr(1'b1, ADDR_POINTER_CONTROL, 8'h7F);
		chk("control", {8'h00, ctrl}, 16'h007D);
		@(negedge clk_i);
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		chk("control", {8'h00, ctrl}, {8'h00, CTRL_RESET});
		chk("select", {15'h0, sel}, 16'h0000);
		rd_chk(ADDR_POINTER_CONTROL, CTRL_RESET);
	endtask : t_reset
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// hang guard, far above the roughly 120 cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_control();
		t_modes();
		t_bytes();
		t_swap();
		t_reset();
		print_verdict();
	end
endmodule : tb
